/* logic/phase_shift_defs.vh */
// register map, field positions, reset values and timing counts of the fine phase shifter
`ifndef PHASE_SHIFT_DEFS_VH
`define PHASE_SHIFT_DEFS_VH
`define ADR_CTRL 6'h00
`define ADR_TIMING 6'h04
`define ADR_TAP 6'h08
`define ADR_STATUS 6'h0C
`define ADR_LIMITS 6'h10
`define ADR_UNITS 6'h14
`define MODE_NONE 2'h0
`define MODE_FIXED 2'h1
`define MODE_VARIABLE 2'h2
`define CTRL_MODE_LSB 0
`define CTRL_MGR_RESET_BIT 4
`define CTRL_INIT_LSB 16
`define ST_OFFSET_LSB 0
`define ST_POS_LSB 16
`define ST_OVF_BIT 28
`define ST_LOCK_BIT 29
`define ST_BUSY_BIT 30
`define RST_MODE 2'h0
`define RST_INIT_OFFSET 9'h000
`define RST_PERIOD_PS 16'h3415
`define RST_RANGE_PS 16'h2710
`define RST_TAP_MIN_PS 16'h001E
`define PTR_MAX 10'h0FF
`define FIXED_SCALE 24'h000100
`define DYN_SCALE 24'h000080
`define FIXED_RATIO 2'h1
`define DYN_RATIO 2'h2
`define SLIDE_DIV 4'h3
`endif

/* logic/phase_range_calc.v */
// limit and step size arithmetic from reference period and guaranteed delay span
`timescale 1ns/1ps
`include "phase_shift_defs.vh"
module phase_range_calc (
  // clock and reset
  input wire CLOCK,
  input wire RST_B,
  // timing figures in picoseconds
  input wire [15:0] PERIOD_PS,
  input wire [15:0] RANGE_PS,
  input wire [15:0] TAP_MIN_PS,
  // results
  output reg [7:0] FIXED_LIMIT,
  output reg [7:0] DYN_LIMIT,
  output reg [15:0] FIXED_UNIT_PS,
  output reg [15:0] DYN_UNIT_PS,
  output reg [15:0] MIN_STEP_PS
);
  // span has reached ratio times the reference period
  function ratio_reached;
    input [15:0] rng;
    input [15:0] per;
    input [1:0] ratio;
    begin
      ratio_reached = ({1'b0, rng} >= per * ratio);
    end
  endfunction
  // integer part of scale * range / period, or 255 when ratio reaches its bound
  function [7:0] span_limit;
    input [15:0] rng;
    input [15:0] per;
    input [23:0] scale;
    input [1:0] ratio;
    reg [23:0] q;
    begin
      q = 24'h000000;
      if (per == 16'h0000)
        span_limit = 8'h00;
      else if (ratio_reached(rng, per, ratio))
        span_limit = 8'hFF;
      else
      begin
        q = (rng * scale) / per;
        span_limit = q[7:0];
      end
    end
  endfunction
  // one unit: span over limit below the bound, period/256 above it
  function [15:0] unit_size;
    input [15:0] rng;
    input [15:0] per;
    input [7:0] lim;
    input full;
    begin
      // a limit of 255 below the bound still divides the span
      if (full)
        unit_size = {8'h00, per[15:8]};
      else if (lim == 8'h00)
        unit_size = 16'h0000;
      else
        unit_size = rng / lim;
    end
  endfunction
  wire [7:0] fixed_lim_d = span_limit(RANGE_PS, PERIOD_PS, `FIXED_SCALE, `FIXED_RATIO);
  wire [7:0] dyn_lim_d = span_limit(RANGE_PS, PERIOD_PS, `DYN_SCALE, `DYN_RATIO);
  wire fixed_full = ratio_reached(RANGE_PS, PERIOD_PS, `FIXED_RATIO);
  wire dyn_full = ratio_reached(RANGE_PS, PERIOD_PS, `DYN_RATIO);
  always @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      FIXED_LIMIT <= 8'h00;
      DYN_LIMIT <= 8'h00;
      FIXED_UNIT_PS <= 16'h0000;
      DYN_UNIT_PS <= 16'h0000;
      MIN_STEP_PS <= 16'h0000;
    end
    else
    begin
      FIXED_LIMIT <= fixed_lim_d;
      DYN_LIMIT <= dyn_lim_d;
      FIXED_UNIT_PS <= unit_size(RANGE_PS, PERIOD_PS, fixed_lim_d, fixed_full);
      DYN_UNIT_PS <= unit_size(RANGE_PS, PERIOD_PS, dyn_lim_d, dyn_full);
      MIN_STEP_PS <= (TAP_MIN_PS > {8'h00, PERIOD_PS[15:8]}) ?
        TAP_MIN_PS : {8'h00, PERIOD_PS[15:8]};
    end
  end
endmodule

/* logic/fine_phase_shift_control.v */
// fine phase shift control: fixed and variable offset, delay line position, wishbone registers
// Function
// - fixed mode takes offset from configuration; no run-time change possible (here a control register write moves it at once)
// - mode selector set to fixed, separate value gives offset amount
// - zero aligns outputs; negative places edges before reference, positive after
// - offset is signed, magnitude at most 255, tighter by period
// - ratio below 1: limit is int(256*ratio), unit is span over limit
// - ratio 1 or more: limit 255, unit is period over 256
// - smallest step is larger of tap resolution and period over 256
// - variable mode starts at configured offset; steps only after lock
// - handshake inputs sampled and outputs updated on shift clock rising edges
// - accepted request adds one unit when direction high, subtracts when low
// - completion pulses high for one shift clock period after variable latency
// - outputs slide gradually to new offset; lock stays asserted meanwhile
// - mode selector set to variable, configured offset is starting position
// - manager reset restores configured offset, discarding run-time steps
// - ratio below 2: dynamic limit int(128*ratio), unit span over limit
// - ratio 2 or more: dynamic limit 255, unit period over 256
// - request low: direction ignored, offset and delay position unchanged
// - step beyond 255 holds limit, sets overflow; opposite step clears it
// - past delay line end pointer keeps moving to 255, overflow high
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "phase_shift_defs.vh"
module fine_phase_shift_control (
  // system
  input wire CLOCK,
  input wire RST_B,
  // wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [5:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // lock loop and dynamic shift handshake
  input wire LOCK_IN,
  input wire SHIFT_CLOCK,
  input wire SHIFT_REQUEST,
  input wire SHIFT_DIRECTION,
  output reg SHIFT_COMPLETE,
  output wire LOCKED,
  output reg OVERFLOW,
  // applied phase
  output reg [8:0] APPLIED_POSITION,
  output reg [25:0] PHASE_SHIFT_PS
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SLIDE = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // configuration registers
  reg [1:0] mode_q;
  reg mgr_reset_q;
  reg [8:0] init_q;
  reg [15:0] period_q;
  reg [15:0] range_q;
  reg [15:0] tap_min_q;
  // dynamic state
  reg [8:0] ptr_q;
  reg [8:0] pos_q;
  reg ovf_dir_q;
  reg [2:0] state_q;
  reg [3:0] slide_cnt_q;
  reg mgr_reset_d1_q;
  reg var_mode_d1_q;
  // synchronisers
  reg [1:0] sclk_sync_q;
  reg [1:0] req_sync_q;
  reg [1:0] dir_sync_q;
  reg [1:0] lock_sync_q;
  reg sclk_prev_q;
  // request and direction as they stood before the detected shift edge
  reg req_prev_q;
  reg dir_prev_q;

  wire [7:0] fixed_limit;
  wire [7:0] dyn_limit;
  wire [15:0] fixed_unit_ps;
  wire [15:0] dyn_unit_ps;
  wire [15:0] min_step_ps;

  phase_range_calc range_calc (
    .CLOCK(CLOCK),
    .RST_B(RST_B),
    .PERIOD_PS(period_q),
    .RANGE_PS(range_q),
    .TAP_MIN_PS(tap_min_q),
    .FIXED_LIMIT(fixed_limit),
    .DYN_LIMIT(dyn_limit),
    .FIXED_UNIT_PS(fixed_unit_ps),
    .DYN_UNIT_PS(dyn_unit_ps),
    .MIN_STEP_PS(min_step_ps)
  );

  // clamp a signed value to plus or minus a magnitude
  function [8:0] clamp;
    input [8:0] val;
    input [7:0] lim;
    reg [9:0] v;
    reg [9:0] l;
    begin
      v = {val[8], val};
      l = {2'h0, lim};
      if ($signed(v) > $signed(l))
        clamp = l[8:0];
      else if ($signed(v) < -$signed(l))
        clamp = 9'h000 - l[8:0];
      else
        clamp = val;
    end
  endfunction

  // shift clock edge found by the system clock
  wire sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
  wire lock_ok = lock_sync_q[1] & ~mgr_reset_q;
  wire variable_mode = (mode_q == `MODE_VARIABLE);
  wire can_accept = (state_q == ST_IDLE) || (state_q == ST_DONE);
  // request ignored unless variable mode, locked and idle or done
  wire step_take = sclk_rise & req_prev_q & variable_mode & lock_ok & can_accept;
  wire slide_tick = (slide_cnt_q == `SLIDE_DIV);
  wire [7:0] op_limit = variable_mode ? dyn_limit : fixed_limit;
  wire [8:0] start_ptr = (mode_q == `MODE_NONE) ? 9'h000 : clamp(init_q, fixed_limit);
  // variable mode keeps the delay line inside the dynamic limit from the start
  wire [8:0] start_pos = variable_mode ? clamp(start_ptr, dyn_limit) : start_ptr;

  assign LOCKED = lock_ok;

  // next pointer, position and overflow of one step
  reg [8:0] ptr_d;
  reg [8:0] pos_d;
  reg blocked_d;
  always @*
  begin
    ptr_d = ptr_q;
    pos_d = pos_q;
    blocked_d = 1'b0;
    if (dir_prev_q)
    begin
      if ($signed({ptr_q[8], ptr_q}) < $signed(`PTR_MAX))
        ptr_d = ptr_q + 9'h001;
    end
    else
    begin
      if ($signed({ptr_q[8], ptr_q}) > -$signed(`PTR_MAX))
        ptr_d = ptr_q - 9'h001;
    end
    pos_d = clamp(ptr_d, dyn_limit);
    blocked_d = (pos_d == pos_q);
  end

  // step state machine on shift clock edges
  always @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      sclk_sync_q <= 2'h0;
      req_sync_q <= 2'h0;
      dir_sync_q <= 2'h0;
      lock_sync_q <= 2'h0;
      sclk_prev_q <= 1'b0;
      req_prev_q <= 1'b0;
      dir_prev_q <= 1'b0;
      state_q <= ST_IDLE;
      SHIFT_COMPLETE <= 1'b0;
      ptr_q <= 9'h000;
      pos_q <= 9'h000;
      APPLIED_POSITION <= 9'h000;
      OVERFLOW <= 1'b0;
      ovf_dir_q <= 1'b0;
      slide_cnt_q <= 4'h0;
      mgr_reset_d1_q <= 1'b1;
      var_mode_d1_q <= 1'b0;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[0], SHIFT_CLOCK};
      req_sync_q <= {req_sync_q[0], SHIFT_REQUEST};
      dir_sync_q <= {dir_sync_q[0], SHIFT_DIRECTION};
      lock_sync_q <= {lock_sync_q[0], LOCK_IN};
      sclk_prev_q <= sclk_sync_q[1];
      req_prev_q <= req_sync_q[1];
      dir_prev_q <= dir_sync_q[1];
      mgr_reset_d1_q <= mgr_reset_q;
      var_mode_d1_q <= variable_mode;
      slide_cnt_q <= slide_tick ? 4'h0 : slide_cnt_q + 4'h1;
      if (mgr_reset_q || mgr_reset_d1_q || !variable_mode || !var_mode_d1_q)
      begin
        // reload configured offset; fixed mode follows every control register write, variable mode starts here
        ptr_q <= start_ptr;
        pos_q <= start_pos;
        APPLIED_POSITION <= start_pos;
        OVERFLOW <= 1'b0;
        ovf_dir_q <= 1'b0;
        state_q <= ST_IDLE;
        SHIFT_COMPLETE <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (step_take)
              state_q <= ST_SLIDE;
          end
          ST_SLIDE:
          begin
            if (APPLIED_POSITION == pos_q && sclk_rise)
            begin
              SHIFT_COMPLETE <= 1'b1;
              state_q <= ST_DONE;
            end
          end
          ST_DONE:
          begin
            if (sclk_rise)
            begin
              SHIFT_COMPLETE <= 1'b0;
              state_q <= step_take ? ST_SLIDE : ST_IDLE;
            end
          end
          default:
          begin
            state_q <= ST_IDLE;
            SHIFT_COMPLETE <= 1'b0;
          end
        endcase
        // request low leaves pointer, position and overflow alone
        if (step_take)
        begin
          ptr_q <= ptr_d;
          pos_q <= pos_d;
          // a step away from the blocked end clears the flag before anything else
          if (OVERFLOW && dir_prev_q != ovf_dir_q)
            OVERFLOW <= 1'b0;
          else if (blocked_d)
          begin
            OVERFLOW <= 1'b1;
            ovf_dir_q <= dir_prev_q;
          end
        end
        // applied delay walks one tap per slide tick
        if (slide_tick && APPLIED_POSITION != pos_q)
        begin
          if ($signed(APPLIED_POSITION) < $signed(pos_q))
            APPLIED_POSITION <= APPLIED_POSITION + 9'h001;
          else
            APPLIED_POSITION <= APPLIED_POSITION - 9'h001;
        end
      end
    end
  end

  // signed time offset of the outputs against the reference
  wire [15:0] unit_ps = variable_mode ? dyn_unit_ps : fixed_unit_ps;
  wire signed [25:0] shift_prod = $signed(APPLIED_POSITION) * $signed({1'b0, unit_ps});
  always @(posedge CLOCK)
  begin
    if (!RST_B)
      PHASE_SHIFT_PS <= 26'h0000000;
    else
      PHASE_SHIFT_PS <= shift_prod;
  end

  // wishbone slave: one wait state, ack drops after one cycle
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I;
  always @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      mode_q <= `RST_MODE;
      mgr_reset_q <= 1'b0;
      init_q <= `RST_INIT_OFFSET;
      period_q <= `RST_PERIOD_PS;
      range_q <= `RST_RANGE_PS;
      tap_min_q <= `RST_TAP_MIN_PS;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h00000000;
      if (wb_wr && WB_ADR_I == `ADR_CTRL)
      begin
        if (WB_SEL_I[0])
        begin
          mode_q <= WB_DAT_I[`CTRL_MODE_LSB +: 2];
          mgr_reset_q <= WB_DAT_I[`CTRL_MGR_RESET_BIT];
        end
        if (WB_SEL_I[2])
          init_q[7:0] <= WB_DAT_I[`CTRL_INIT_LSB +: 8];
        if (WB_SEL_I[3])
          init_q[8] <= WB_DAT_I[`CTRL_INIT_LSB + 8];
      end
      if (wb_wr && WB_ADR_I == `ADR_TIMING)
      begin
        if (WB_SEL_I[0])
          period_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1])
          period_q[15:8] <= WB_DAT_I[15:8];
        if (WB_SEL_I[2])
          range_q[7:0] <= WB_DAT_I[23:16];
        if (WB_SEL_I[3])
          range_q[15:8] <= WB_DAT_I[31:24];
      end
      if (wb_wr && WB_ADR_I == `ADR_TAP)
      begin
        if (WB_SEL_I[0])
          tap_min_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1])
          tap_min_q[15:8] <= WB_DAT_I[15:8];
      end
      if (wb_req && !WB_WE_I)
      begin
        case (WB_ADR_I)
          `ADR_CTRL:
            WB_DAT_O <= {7'h00, init_q, 11'h000, mgr_reset_q, 2'h0, mode_q};
          `ADR_TIMING:
            WB_DAT_O <= {range_q, period_q};
          `ADR_TAP:
            WB_DAT_O <= {16'h0000, tap_min_q};
          `ADR_STATUS:
            WB_DAT_O <= {1'b0, (state_q != ST_IDLE), lock_ok, OVERFLOW, 3'h0,
              APPLIED_POSITION, 7'h00, ptr_q};
          `ADR_LIMITS:
            WB_DAT_O <= {min_step_ps, dyn_limit, fixed_limit};
          `ADR_UNITS:
            WB_DAT_O <= {dyn_unit_ps, fixed_unit_ps};
          default:
            WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

  // operating limit of the active mode, kept only on an unused wire and read by no logic
  wire unused_limit = |op_limit;
endmodule

/* bench/fine_phase_shift_control_checker.sv */
// port checker for the fine phase shift control block
`timescale 1ns/1ps
module fine_phase_shift_control_checker (
  // system
  input wire CLOCK,
  input wire RST_B,
  // bus
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire [31:0] WB_DAT_O,
  // shift side
  input wire LOCK_IN,
  input wire SHIFT_CLOCK,
  input wire SHIFT_COMPLETE,
  input wire LOCKED,
  input wire OVERFLOW,
  input wire [8:0] APPLIED_POSITION,
  input wire [25:0] PHASE_SHIFT_PS
);
  reg sclk_q;
  reg [3:0] age_q;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  // cycles since the shift clock pin was seen rising
  always @(posedge CLOCK)
  begin
    sclk_q <= SHIFT_CLOCK;
    if (SHIFT_CLOCK && !sclk_q)
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  end
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_hold;
    SHIFT_COMPLETE [*8] ##1 !SHIFT_COMPLETE;
  endsequence
  a_ack_answer: assert property (s_req |=> WB_ACK_O)
    else $error("no ack after request");
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("data outside ack");
  a_done_width: assert property ($rose(SHIFT_COMPLETE) |-> s_hold)
    else $error("completion width wrong");
  a_done_edge: assert property ($rose(SHIFT_COMPLETE) |-> age_q inside {[4'h1:4'h5]})
    else $error("completion off shift edge");
  a_lock_sync: assert property ($rose(LOCKED) |-> $past(LOCK_IN, 2))
    else $error("lock rose alone");
  a_ovf_still: assert property ($rose(OVERFLOW) |-> $stable(APPLIED_POSITION))
    else $error("position moved on overflow");
  a_zero_align: assert property ((APPLIED_POSITION == 9'h0) [*2] |-> PHASE_SHIFT_PS == 26'h0)
    else $error("zero position not aligned");
  a_sign_before: assert property (($signed(APPLIED_POSITION) < 0) [*2] |-> PHASE_SHIFT_PS[25])
    else $error("negative position not before");
endmodule

/* bench/shift_user_model.sv */
// user logic model driving the dynamic shift handshake
`timescale 1ns/1ps
module shift_user_model (
  // enable from bench
  input wire en,
  // handshake
  output reg SHIFT_CLOCK,
  output reg SHIFT_REQUEST,
  output reg SHIFT_DIRECTION,
  input wire SHIFT_COMPLETE
);
  reg busy_q;
  initial
  begin
    SHIFT_CLOCK = 1'h0;
    SHIFT_REQUEST = 1'h0;
    SHIFT_DIRECTION = 1'h0;
    busy_q = 1'h0;
    #37;
    forever
      #400 SHIFT_CLOCK = en & ~SHIFT_CLOCK;
  end
  // idle direction wanders; the block must ignore it
  always @(posedge SHIFT_CLOCK or negedge en)
    if (!en)
      SHIFT_DIRECTION <= 1'h0;
    else if (!busy_q)
      SHIFT_DIRECTION <= ~SHIFT_DIRECTION;
  task step(input reg d, output reg ok);
    integer k;
    begin
      busy_q = 1'h1;
      ok = 1'h0;
      @(posedge SHIFT_CLOCK);
      SHIFT_REQUEST <= 1'h1;
      SHIFT_DIRECTION <= d;
      @(posedge SHIFT_CLOCK);
      SHIFT_REQUEST <= 1'h0;
      for (k = 0; k < 40 && !ok; k = k + 1)
      begin
        @(posedge SHIFT_CLOCK);
        ok = SHIFT_COMPLETE === 1'h1;
      end
      busy_q = 1'h0;
    end
  endtask
endmodule

/* bench/fine_phase_shift_control_tb.sv */
// self-checking bench for the fine phase shift control block
`timescale 1ns/1ps
`include "phase_shift_defs.vh"
module fine_phase_shift_control_tb;
  reg clock, rst_b, cyc, stb, we, lock_in, en, ok;
  reg [5:0] adr;
  reg [31:0] wdat, s;
  reg [63:0] e;
  wire ack, sclk, sreq, sdir, done, locked, ovf;
  wire [31:0] rdat;
  wire [8:0] pos;
  wire [25:0] ps;
  integer errors, n_checks, i, p, r, v, fl, ptr, ep, dl, du, bd, eo;
  fine_phase_shift_control u_fine_phase_shift_control (.CLOCK(clock), .RST_B(rst_b),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .LOCK_IN(lock_in),
    .SHIFT_CLOCK(sclk), .SHIFT_REQUEST(sreq), .SHIFT_DIRECTION(sdir),
    .SHIFT_COMPLETE(done), .LOCKED(locked), .OVERFLOW(ovf),
    .APPLIED_POSITION(pos), .PHASE_SHIFT_PS(ps));
  shift_user_model u_shift_user_model (.en(en), .SHIFT_CLOCK(sclk),
    .SHIFT_REQUEST(sreq), .SHIFT_DIRECTION(sdir), .SHIFT_COMPLETE(done));
  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x)
      begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wb(input w, input [5:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clock);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clock);
      for (k = 0; ack !== 1'h1 && k < 20; k = k + 1)
        @(posedge clock);
      s = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      if (k == 20)
      begin
        chk(32'h0, 32'h1);
        finish_test;
      end
    end
  endtask
  function [63:0] expect_regs(input integer p, input integer r, input integer t);
    integer f, d, uf, ud, m;
    begin
      f = (r >= p) ? 255 : 256 * r / p;
      d = (r >= 2 * p) ? 255 : 128 * r / p;
      uf = (r >= p) ? p / 256 : (f ? r / f : 0);
      ud = (r >= 2 * p) ? p / 256 : (d ? r / d : 0);
      m = (t > p / 256) ? t : p / 256;
      expect_regs = {ud[15:0], uf[15:0], m[15:0], d[7:0], f[7:0]};
    end
  endfunction
  task lim_check(input integer p, input integer r, input integer t);
    begin
      wb(1'h1, `ADR_TIMING, {r[15:0], p[15:0]});
      wb(1'h1, `ADR_TAP, t);
      repeat (3) @(posedge clock);
      e = expect_regs(p, r, t);
      wb(1'h0, `ADR_LIMITS, 0);
      chk(s, e[31:0]);
      wb(1'h0, `ADR_UNITS, 0);
      chk(s, e[63:32]);
    end
  endtask
  task wait_pos(input integer x);
    integer k;
    begin
      for (k = 0; k < 3000 && pos !== x[8:0]; k = k + 1)
        @(posedge clock);
      chk({23'h0, pos}, {23'h0, x[8:0]});
      if (pos !== x[8:0])
        finish_test;
    end
  endtask
  task step(input integer d);
    integer np, npos;
    begin
      u_shift_user_model.step(d[0], ok);
      np = d ? (ptr < 255 ? ptr + 1 : 255) : (ptr > -255 ? ptr - 1 : -255);
      npos = np > dl ? dl : (np < -dl ? -dl : np);
      if (eo && d != bd)
        eo = 0;
      else if (npos == ep)
      begin
        eo = 1;
        bd = d;
      end
      ptr = np;
      ep = npos;
      chk({31'h0, ok}, 32'h1);
      if (!ok)
        finish_test;
      wb(1'h0, `ADR_STATUS, 0);
      chk(s & 32'hBFFFFFFF, {3'h1, eo[0], 3'h0, ep[8:0], 7'h0, ptr[8:0]});
      chk({31'h0, ovf}, eo);
      chk({31'h0, locked}, 32'h1);
      chk({{6{ps[25]}}, ps}, ep * du);
    end
  endtask
  task steps(input integer n, input integer d);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1)
      begin
        repeat ($urandom % 9) @(posedge clock);
        step(d > 1 ? $urandom % 2 : d);
      end
    end
  endtask
  initial
  begin
    errors = 0;
    n_checks = 0;
    rst_b = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 6'h0;
    wdat = 32'h0;
    lock_in = 1'h0;
    en = 1'h0;
    void'($urandom(32'h694F));
    repeat (16) @(posedge clock);
    rst_b <= 1'h1;
    wb(1'h0, `ADR_CTRL, 0);
    chk(s, 32'h0);
    wb(1'h0, `ADR_TIMING, 0);
    chk(s, 32'h27103415);
    wb(1'h0, `ADR_TAP, 0);
    chk(s, 32'h1E);
    wb(1'h1, 6'h18, 32'hFFFFFFFF);
    wb(1'h0, 6'h18, 0);
    chk(s, 32'h0);
    wb(1'h0, `ADR_STATUS, 0);
    chk(s, 32'h0);
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1)
    begin
      p = 1000 + $urandom % 30000;
      r = i == 0 ? p : i == 1 ? 2 * p : i == 2 ? 2 * p - 1 : $urandom % 65536;
      lim_check(p, r, $urandom % 300);
    end
    lim_check(13333, 10000, 30);
    dl = e[15:8];
    du = e[63:48];
    fl = e[7:0];
    $display("limit test done");
    lock_in <= 1'h1;
    for (i = 0; i < 5; i = i + 1)
    begin
      v = i == 4 ? 255 : $signed($urandom % 511) - 255;
      wb(1'h1, `ADR_CTRL, {7'h0, v[8:0], 14'h0, `MODE_FIXED});
      wait_pos(v > fl ? fl : v < -fl ? -fl : v);
    end
    $display("fixed test done");
    wb(1'h1, `ADR_CTRL, {7'h0, 9'h05A, 14'h0, `MODE_VARIABLE});
    ptr = 90;
    ep = 90;
    eo = 0;
    bd = 0;
    wait_pos(90);
    en <= 1'h1;
    lock_in <= 1'h0;
    repeat (8) @(posedge clock);
    chk({31'h0, locked}, 32'h0);
    u_shift_user_model.step(1'h1, ok);
    chk({31'h0, ok}, 32'h0);
    wait_pos(90);
    lock_in <= 1'h1;
    repeat (8) @(posedge clock);
    steps(8, 2);
    steps(175, 1);
    steps(2, 0);
    repeat (20) @(posedge clock);
    wb(1'h1, `ADR_CTRL, {7'h0, 9'h16A, 14'h4, `MODE_VARIABLE});
    wb(1'h1, `ADR_CTRL, {7'h0, 9'h16A, 14'h0, `MODE_VARIABLE});
    ptr = -150;
    ep = -dl;
    eo = 0;
    bd = 0;
    wait_pos(-dl);
    chk({31'h0, ovf}, eo);
    steps(110, 0);
    steps(1, 1);
    $display("variable test done");
    finish_test;
  end
endmodule
bind fine_phase_shift_control fine_phase_shift_control_checker u_checker (.CLOCK(CLOCK),
  .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .WB_DAT_O(WB_DAT_O), .LOCK_IN(LOCK_IN), .SHIFT_CLOCK(SHIFT_CLOCK),
  .SHIFT_COMPLETE(SHIFT_COMPLETE), .LOCKED(LOCKED), .OVERFLOW(OVERFLOW),
  .APPLIED_POSITION(APPLIED_POSITION), .PHASE_SHIFT_PS(PHASE_SHIFT_PS));
